// ==== vblank_pkg.sv ====
/*
 * Package for the vertical blanking generator: register offsets, field
 * positions, reset values and mode codes.
 * Assumes a 32-bit APB register bus with word-aligned registers.
 */
package vblank_pkg;

    // Register byte offsets on the APB bus.
    localparam logic [7:0] OFF_F1_START = 8'h00;
    localparam logic [7:0] OFF_F1_END = 8'h04;
    localparam logic [7:0] OFF_F2_START = 8'h08;
    localparam logic [7:0] OFF_F2_END = 8'h0C;
    localparam logic [7:0] OFF_VBIT = 8'h10;
    localparam logic [7:0] OFF_FRAME = 8'h14;
    localparam logic [7:0] OFF_CTRL = 8'h18;
    localparam logic [7:0] OFF_STATUS = 8'h1C;

    // Field positions inside every position register.
    localparam int LINE_LSB = 16;
    localparam int LINE_MSB = 27;
    localparam int PIX_LSB = 0;
    localparam int PIX_MSB = 11;
    localparam int POS_W = 12;

    // Valid bits of a position register; the rest read as zero.
    localparam logic [31:0] POS_MASK = 32'h0FFF_0FFF;

    // Reset values.
    localparam logic [31:0] POS_RESET = 32'h0000_0000;
    localparam logic [11:0] LINE_TOTAL_RESET = 12'h20D;
    localparam logic [11:0] PIX_TOTAL_RESET = 12'h35A;
    localparam logic [11:0] COUNT_START = 12'h001;

    // Control bit positions.
    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_MODE_LSB = 1;
    localparam int VBIT_F1_BIT = 0;
    localparam int VBIT_F2_BIT = 1;

    // Output modes; the blanking output behaves the same in all of them.
    typedef enum logic [1:0] {
        MODE_RAW = 2'h0,
        MODE_BT656 = 2'h1,
        MODE_YC = 2'h2
    } out_mode_t;

    // Memory depth for the position table.
    localparam int NUM_POS = 4;

endpackage : vblank_pkg

// ==== pos_table.sv ====
/*
 * Small register table holding the four blanking positions.
 * Assumes one writer and one reader, both in the pclk domain.
 * Read data come out of a register one cycle after the address.
 */
module pos_table (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic wr_en,
    input wire logic [1:0] wr_idx,
    input wire logic [31:0] wr_data,
    input wire logic [1:0] rd_idx,
    output logic [31:0] rd_data,
    output logic [4*32-1:0] all_data
);

    logic [31:0] mem_ff [vblank_pkg::NUM_POS];
    logic [31:0] rd_ff;

    // One storage word per entry; reserved bits are dropped on write.
    genvar g;
    generate
        for (g = 0; g < vblank_pkg::NUM_POS; g++) begin : g_ent
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    mem_ff[g] <= vblank_pkg::POS_RESET;
                end else if (wr_en && wr_idx == 2'(g)) begin
                    mem_ff[g] <= wr_data & vblank_pkg::POS_MASK;
                end
            end
            assign all_data[g*32 +: 32] = mem_ff[g];
        end
    endgenerate

    // Registered read port.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rd_ff <= 32'h0000_0000;
        end else begin
            rd_ff <= mem_ff[rd_idx];
        end
    end

    assign rd_data = rd_ff;

endmodule : pos_table

// ==== vertical_blanking_generator.sv ====
/*
 * Vertical blanking generator for an interlaced display port with two fields.
 * Frame line and pixel counters are compared with programmed positions to
 * set and clear the blanking output.
 * Assumes an APB master in the pclk domain; pclk is the pixel clock.
 */
module vertical_blanking_generator (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic vertical_blank_out,
    output logic field_id,
    output logic vbit_code
);

    typedef enum logic [1:0] {
        ACC_IDLE = 2'b01,
        ACC_READ = 2'b10
    } acc_state_t;

    acc_state_t acc_ff;
    acc_state_t nxt_acc;

    logic [31:0] prdata_ff;
    logic pready_ff;
    logic pslverr_ff;
    logic [31:0] vbit_ff;
    logic [31:0] frame_ff;
    logic [31:0] ctrl_ff;
    logic [11:0] frame_line_counter_ff;
    logic [11:0] frame_pixel_counter_ff;
    logic vblank_ff;
    logic field_ff;
    logic vbit_out_ff;

    // Address decode, done combinationally from the setup-phase address.
    wire setup = psel && !penable;
    wire is_pos = (paddr[7:4] == 4'h0) && (paddr[1:0] == 2'b00);
    wire is_vbit = paddr == vblank_pkg::OFF_VBIT;
    wire is_frame = paddr == vblank_pkg::OFF_FRAME;
    wire is_ctrl = paddr == vblank_pkg::OFF_CTRL;
    wire is_stat = paddr == vblank_pkg::OFF_STATUS;
    wire mapped = is_pos || is_vbit || is_frame || is_ctrl || is_stat;
    wire wr_take = psel && penable && pwrite && pready_ff;
    wire pos_wr = wr_take && is_pos;
    wire [1:0] pos_idx = paddr[3:2];

    wire [31:0] pos_rd;
    wire [4*32-1:0] pos_all;

    // Position registers live in the table; reserved bits never stored.
    pos_table u_pos (
        .pclk(pclk),
        .presetn(presetn),
        .wr_en(pos_wr),
        .wr_idx(pos_idx),
        .wr_data(pwdata),
        .rd_idx(pos_idx),
        .rd_data(pos_rd),
        .all_data(pos_all)
    );

    // Unpack programmed positions into their line and pixel fields.
    wire [31:0] f1s = pos_all[0*32 +: 32];
    wire [31:0] f1e = pos_all[1*32 +: 32];
    wire [31:0] f2s = pos_all[2*32 +: 32];
    wire [31:0] f2e = pos_all[3*32 +: 32];
    wire [11:0] f1_blank_start_line = f1s[vblank_pkg::LINE_MSB:vblank_pkg::LINE_LSB];
    wire [11:0] f1_blank_start_pixel = f1s[vblank_pkg::PIX_MSB:vblank_pkg::PIX_LSB];
    wire [11:0] f1_blank_end_line = f1e[vblank_pkg::LINE_MSB:vblank_pkg::LINE_LSB];
    wire [11:0] f1_blank_end_pixel = f1e[vblank_pkg::PIX_MSB:vblank_pkg::PIX_LSB];
    wire [11:0] f2_blank_start_line = f2s[vblank_pkg::LINE_MSB:vblank_pkg::LINE_LSB];
    wire [11:0] f2_blank_start_pixel = f2s[vblank_pkg::PIX_MSB:vblank_pkg::PIX_LSB];
    wire [11:0] f2_blank_end_line = f2e[vblank_pkg::LINE_MSB:vblank_pkg::LINE_LSB];
    wire [11:0] f2_blank_end_pixel = f2e[vblank_pkg::PIX_MSB:vblank_pkg::PIX_LSB];

    wire [11:0] frame_line_total = frame_ff[vblank_pkg::LINE_MSB:vblank_pkg::LINE_LSB];
    wire [11:0] frame_pixel_total = frame_ff[vblank_pkg::PIX_MSB:vblank_pkg::PIX_LSB];
    wire run = ctrl_ff[vblank_pkg::CTRL_EN_BIT];
    wire field1_vbit_control = vbit_ff[vblank_pkg::VBIT_F1_BIT];
    wire field2_vbit_control = vbit_ff[vblank_pkg::VBIT_F2_BIT];

    // Counter wrap points; pixel total counts pixels, so last is total-1.
    wire pix_last = frame_pixel_counter_ff >= frame_pixel_total - 12'h001;
    wire line_last = frame_line_counter_ff >= frame_line_total;
    wire [11:0] nxt_pixel = pix_last ? 12'h000 : frame_pixel_counter_ff + 12'h001;
    wire [11:0] nxt_line = !pix_last ? frame_line_counter_ff :
                           line_last ? vblank_pkg::COUNT_START :
                           frame_line_counter_ff + 12'h001;

    // Blanking compares; mode bits deliberately take no part here.
    wire hit_f1s = frame_line_counter_ff == f1_blank_start_line &&
                   frame_pixel_counter_ff == f1_blank_start_pixel;
    wire hit_f1e = frame_line_counter_ff == f1_blank_end_line &&
                   frame_pixel_counter_ff == f1_blank_end_pixel;
    wire hit_f2s = frame_line_counter_ff == f2_blank_start_line &&
                   frame_pixel_counter_ff == f2_blank_start_pixel;
    wire hit_f2e = frame_line_counter_ff == f2_blank_end_line &&
                   frame_pixel_counter_ff == f2_blank_end_pixel;
    wire set_blank = hit_f1s || hit_f2s;
    wire clr_blank = hit_f1e || hit_f2e;
    // A start match wins if it coincides with an end match.
    wire nxt_vblank = set_blank ? 1'b1 : clr_blank ? 1'b0 : vblank_ff;

    // Field flag: field 2 from its start position until field 1 starts.
    wire nxt_field = hit_f2s ? 1'b1 : hit_f1s ? 1'b0 : field_ff;
    wire nxt_vbit = nxt_field ? field2_vbit_control : field1_vbit_control;

    // Read data mux; unmapped addresses read zero and flag an error.
    wire [31:0] nxt_rdata = is_vbit ? (vbit_ff & 32'h0000_0003) :
                            is_frame ? frame_ff :
                            is_ctrl ? ctrl_ff :
                            is_stat ? {16'h0000, 4'h0, frame_line_counter_ff[11:0]} |
                                      {29'h0, vbit_out_ff, field_ff, vblank_ff} << 0 :
                            32'h0000_0000;

    // Position reads need one extra cycle for the registered table port.
    always_comb begin
        nxt_acc = acc_ff;
        case (acc_ff)
            ACC_IDLE: if (setup && !pwrite && is_pos) nxt_acc = ACC_READ;
            ACC_READ: nxt_acc = ACC_IDLE;
            default: nxt_acc = ACC_IDLE;
        endcase
    end

    // APB slave: all accesses except position reads answer in the first access cycle.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            acc_ff <= ACC_IDLE;
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff <= 32'h0000_0000;
        end else begin
            acc_ff <= nxt_acc;
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            if (setup && !(is_pos && !pwrite)) begin
                pready_ff <= 1'b1;
                pslverr_ff <= !mapped;
                prdata_ff <= pwrite ? 32'h0000_0000 : nxt_rdata;
            end else if (acc_ff == ACC_READ) begin
                pready_ff <= 1'b1;
                prdata_ff <= pos_rd;
            end
        end
    end

    // Software-owned registers other than the position table.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            vbit_ff <= 32'h0000_0000;
            frame_ff <= {4'h0, vblank_pkg::LINE_TOTAL_RESET, 4'h0, vblank_pkg::PIX_TOTAL_RESET};
            ctrl_ff <= 32'h0000_0000;
        end else if (wr_take && mapped) begin
            if (is_vbit) vbit_ff <= pwdata & 32'h0000_0003;
            if (is_frame) frame_ff <= pwdata & vblank_pkg::POS_MASK;
            if (is_ctrl) ctrl_ff <= pwdata & 32'h0000_0007;
        end
    end

    // Frame counters and blanking output, advanced every pixel clock while the enable bit is set.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            frame_line_counter_ff <= vblank_pkg::COUNT_START;
            frame_pixel_counter_ff <= 12'h000;
            vblank_ff <= 1'b0;
            field_ff <= 1'b0;
            vbit_out_ff <= 1'b0;
        end else if (run) begin
            frame_pixel_counter_ff <= nxt_pixel;
            frame_line_counter_ff <= nxt_line;
            vblank_ff <= nxt_vblank;
            field_ff <= nxt_field;
            vbit_out_ff <= nxt_vbit;
        end
    end

    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign vertical_blank_out = vblank_ff;
    assign field_id = field_ff;
    assign vbit_code = vbit_out_ff;

    // Blanking rises one clock after a start match.
    a_start_sets: assert property (@(posedge pclk) disable iff (!presetn)
        run && set_blank |=> vertical_blank_out)
        else $error("blanking did not rise at start match");

    // Blanking falls one clock after an end match without a start match.
    a_end_clears: assert property (@(posedge pclk) disable iff (!presetn)
        run && clr_blank && !set_blank |=> !vertical_blank_out)
        else $error("blanking did not fall at end match");

    // Output only moves after a matching compare.
    a_output_holds: assert property (@(posedge pclk) disable iff (!presetn)
        !(run && (set_blank || clr_blank)) |=> $stable(vertical_blank_out))
        else $error("blanking changed without a match");

    // Mode bits never influence the blanking output.
    a_mode_indep: assert property (@(posedge pclk) disable iff (!presetn)
        run && !set_blank && !clr_blank && $changed(ctrl_ff[2:1])
        |=> $stable(vertical_blank_out))
        else $error("mode change disturbed blanking");

    // Line counter restarts at COUNT_START after the last pixel of the last line.
    a_line_wrap: assert property (@(posedge pclk) disable iff (!presetn)
        run && pix_last && line_last |=> frame_line_counter_ff == vblank_pkg::COUNT_START)
        else $error("line counter failed to wrap");

    // V bit follows the selected field's control bit.
    a_vbit_f1: assert property (@(posedge pclk) disable iff (!presetn)
        run && !nxt_field |=> vbit_code == $past(field1_vbit_control))
        else $error("field-1 V bit wrong");

    a_vbit_f2: assert property (@(posedge pclk) disable iff (!presetn)
        run && nxt_field |=> vbit_code == $past(field2_vbit_control))
        else $error("field-2 V bit wrong");

    // Reserved bits of position reads stay zero.
    a_resv_zero: assert property (@(posedge pclk) disable iff (!presetn)
        pready && acc_ff == ACC_IDLE && $past(acc_ff) == ACC_READ |->
        (prdata & ~vblank_pkg::POS_MASK) == 32'h0000_0000)
        else $error("reserved bits read non-zero");

    // Field-1 end register holds line and pixel where written.
    a_f1e_fields: assert property (@(posedge pclk) disable iff (!presetn)
        pos_wr && pos_idx == 2'h1 |=> f1_blank_end_line == $past(pwdata[27:16]) &&
        f1_blank_end_pixel == $past(pwdata[11:0]))
        else $error("field-1 end fields not stored");

    c_blank_rise: cover property (@(posedge pclk) $rose(vertical_blank_out));
    c_blank_fall: cover property (@(posedge pclk) $fell(vertical_blank_out));
    c_field2: cover property (@(posedge pclk) $rose(field_id));
    c_pos_read: cover property (@(posedge pclk) acc_ff == ACC_READ);

endmodule : vertical_blanking_generator

// ==== vblank_display_sink.sv ====
/*
 * Display-side model for the vertical blanking generator: it measures how
 * long the blanking output stays high and low in each field.
 * Assumes the blanking and field outputs are registered on pclk.
 */
module vblank_display_sink (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic vertical_blank_out,
    input wire logic field_id,
    output logic [15:0] hi_f1,
    output logic [15:0] hi_f2,
    output logic [15:0] lo_f1,
    output logic [15:0] lo_f2
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [15:0] run_len;
    logic prev_blank;
    // A display only sees levels, so it times each level between changes.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run_len <= 16'h0001;
            prev_blank <= 1'b0;
            hi_f1 <= 16'h0000;
            hi_f2 <= 16'h0000;
            lo_f1 <= 16'h0000;
            lo_f2 <= 16'h0000;
        end else begin
            prev_blank <= vertical_blank_out;
            run_len <= run_len + 16'h0001;
            if (vertical_blank_out !== prev_blank) begin
                run_len <= 16'h0001;
                // Field flag flips with the rising edge, so a low belongs to the other field.
                if (prev_blank && !field_id) hi_f1 <= run_len;
                if (prev_blank && field_id) hi_f2 <= run_len;
                if (!prev_blank && field_id) lo_f1 <= run_len;
                if (!prev_blank && !field_id) lo_f2 <= run_len;
            end
        end
    end
endmodule : vblank_display_sink

// ==== vertical_blanking_generator_bench.sv ====
/*
 * Self-checking bench for the vertical blanking generator, driven over APB.
 * Assumes a shortened frame of 8 lines by 16 pixels set through the frame register.
 */
module vertical_blanking_generator_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic vertical_blank_out;
    logic field_id;
    logic vbit_code;
    logic [15:0] hi_f1, hi_f2, lo_f1, lo_f2;
    logic [31:0] rd;
    logic err;
    logic lvl;
    int fail_count = 0;
    int checks = 0;
    int cycles = 0;
    int changes;

    always #10 pclk = ~pclk;

    vertical_blanking_generator dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .vertical_blank_out(vertical_blank_out), .field_id(field_id), .vbit_code(vbit_code));

    vblank_display_sink sink (.pclk(pclk), .presetn(presetn),
        .vertical_blank_out(vertical_blank_out), .field_id(field_id),
        .hi_f1(hi_f1), .hi_f2(hi_f2), .lo_f1(lo_f1), .lo_f2(lo_f2));

    task summarize;
        $display("checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : summarize

    task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    // One APB transfer; pready is read at the rising edge before the flops update.
    task xfer(input logic [7:0] a, input logic w, input logic [31:0] wd);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= a;
        pwrite <= w;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : xfer

    task rd_chk(input logic [7:0] a, input logic [31:0] exp);
        xfer(a, 1'b0, 32'h0000_0000);
        chk("prdata", exp, rd);
    endtask : rd_chk

    task wait_field(input logic f);
        int n;
        n = 0;
        while (field_id !== f && n < 300) begin
            @(posedge pclk);
            n++;
        end
        repeat (3) @(posedge pclk);
        chk("field id", {31'h0, f}, {31'h0, field_id});
    endtask : wait_field

    // A hang ends the run through the same report.
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fail_count++;
            summarize();
        end
    end

    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 4; i++) rd_chk(8'(4 * i), 32'h0000_0000);
        rd_chk(vblank_pkg::OFF_FRAME, 32'h020D_035A);
        for (int i = 0; i < 4; i++) begin
            xfer(8'(4 * i), 1'b1, 32'hFFFF_FFFF);
            rd_chk(8'(4 * i), 32'h0FFF_0FFF);
        end
        xfer(8'h20, 1'b0, 32'h0000_0000);
        chk("pslverr", 32'h0000_0001, {31'h0, err});
        chk("unmapped", 32'h0000_0000, rd);
        $display("test registers done");
        xfer(vblank_pkg::OFF_FRAME, 1'b1, 32'h0008_0010);
        xfer(vblank_pkg::OFF_F1_START, 1'b1, 32'h0002_0003);
        xfer(vblank_pkg::OFF_F1_END, 1'b1, 32'h0003_0005);
        xfer(vblank_pkg::OFF_F2_START, 1'b1, 32'h0006_0004);
        xfer(vblank_pkg::OFF_F2_END, 1'b1, 32'h0007_0009);
        xfer(vblank_pkg::OFF_VBIT, 1'b1, 32'h0000_0000);
        // Every output mode must give the same blanking periods.
        for (int m = 0; m < 3; m++) begin
            xfer(vblank_pkg::OFF_CTRL, 1'b1, {29'h0, 2'(m), 1'b1});
            repeat (300) @(posedge pclk);
            chk("f1 high", 32'h0000_0012, {16'h0, hi_f1});
            chk("f2 high", 32'h0000_0015, {16'h0, hi_f2});
            chk("f1 low", 32'h0000_002F, {16'h0, lo_f1});
            chk("f2 low", 32'h0000_002A, {16'h0, lo_f2});
        end
        $display("test blanking done");
        for (int v = 1; v < 3; v++) begin
            xfer(vblank_pkg::OFF_VBIT, 1'b1, 32'(v));
            wait_field(1'b0);
            chk("vbit f1", {31'h0, 1'(v)}, {31'h0, vbit_code});
            wait_field(1'b1);
            chk("vbit f2", {31'h0, 1'(v >> 1)}, {31'h0, vbit_code});
        end
        $display("test vbit done");
        xfer(vblank_pkg::OFF_CTRL, 1'b0, 32'h0000_0000);
        chk("ctrl", 32'h0000_0005, rd);
        xfer(vblank_pkg::OFF_CTRL, 1'b1, 32'h0000_0000);
        @(posedge pclk);
        lvl = vertical_blank_out;
        changes = 0;
        repeat (200) begin
            @(posedge pclk);
            if (vertical_blank_out !== lvl) changes++;
        end
        chk("frozen", 32'h0000_0000, 32'(changes));
        $display("test freeze done");
        summarize();
    end
endmodule : vertical_blanking_generator_bench
